// [rtl/streaming_fft_core.v]
`include "fft_consts.vh"
`default_nettype none
module streaming_fft_core (
	input  wire                mclk,
	input  wire                reset_n,
	input  wire                sink_valid,
	output wire                sink_ready,
	input  wire                sink_sop,
	input  wire                sink_eop,
	input  wire                inverse,
	input  wire [`FFT_DW-1:0]  sink_real,
	input  wire [`FFT_DW-1:0]  sink_imag,
	input  wire                source_ready,
	output wire                source_valid,
	output wire                source_sop,
	output wire                source_eop,
	output wire [`FFT_DW-1:0]  source_real,
	output wire [`FFT_DW-1:0]  source_imag,
	output wire [5:0]          exponent_out
);
	// Input side state
	reg                  sink_ready_ff;
	reg  [`FFT_IW-1:0]   idx_ff;
	reg                  inv_ff;
	// Twiddle stage
	reg  [`FFT_DW-1:0]   tw_re_ff;
	reg  [`FFT_DW-1:0]   tw_im_ff;
	reg  [`FFT_IW-1:0]   tw_idx_ff;
	reg  [1:0]           tw_tag_ff;
	// Reorder memory: two banks of one block each
	reg  [`FFT_DW-1:0]   bank_re [0:31];
	reg  [`FFT_DW-1:0]   bank_im [0:31];
	reg  [1:0]           bank_inv_ff;
	reg  [1:0]           full_ff;
	reg                  wb_ff;
	reg                  rb_ff;
	reg  [`FFT_IW-1:0]   ridx_ff;
	// Output registers
	reg                  src_valid_ff;
	reg                  src_sop_ff;
	reg                  src_eop_ff;
	reg  [`FFT_DW-1:0]   src_re_ff;
	reg  [`FFT_DW-1:0]   src_im_ff;
	reg  [5:0]           exp_ff;
	// Combinational helpers
	reg  [1:0]           nxt_full;
	reg                  nxt_wb;
	reg  [`FFT_DW-1:0]   mul_re;
	reg  [`FFT_DW-1:0]   mul_im;
	reg  [31:0]          tw;
	reg  signed [31:0]   p_rr;
	reg  signed [31:0]   p_ii;
	reg  signed [31:0]   p_ri;
	reg  signed [31:0]   p_ir;
	reg  [3:0]           tw_exp;

	wire                 adv;
	wire [`FFT_IW-1:0]   cur_idx;
	wire                 cur_inv;
	wire [`FFT_DW-1:0]   in_re;
	wire [`FFT_DW-1:0]   in_im;
	wire [`FFT_DW-1:0]   s0_re, s0_im, s1_re, s1_im, s2_re, s2_im, s3_re, s3_im;
	wire [`FFT_IW-1:0]   s0_idx, s1_idx, s2_idx, s3_idx;
	wire [1:0]           s0_tag, s1_tag, s2_tag, s3_tag;
	wire                 wr_en;
	wire [4:0]           wr_addr;
	wire                 rd_load;
	wire                 rd_last;
	wire [4:0]           rd_addr;

	// Bit-reversal of a block index
	function [3:0] bitrev4;
		input [3:0] v;
		begin
			bitrev4 = {v[0], v[1], v[2], v[3]};
		end
	endfunction

	// Last index of a block, shared by the write and read sides
	function is_last;
		input [3:0] v;
		begin
			is_last = (v == `FFT_LAST_IDX);
		end
	endfunction

	// Twiddle table, Q2.14, for exponents 0..9 of the 16th root of unity
	function [31:0] twiddle_lut;
		input [3:0] e;
		begin
			case (e)
				4'h0: twiddle_lut = {16'h4000, 16'h0000};
				4'h1: twiddle_lut = {16'h3B21, 16'hE782};
				4'h2: twiddle_lut = {16'h2D41, 16'hD2BF};
				4'h3: twiddle_lut = {16'h187E, 16'hC4DF};
				4'h4: twiddle_lut = {16'h0000, 16'hC000};
				4'h5: twiddle_lut = {16'hE782, 16'hC4DF};
				4'h6: twiddle_lut = {16'hD2BF, 16'hD2BF};
				4'h7: twiddle_lut = {16'hC4DF, 16'hE782};
				4'h8: twiddle_lut = {16'hC000, 16'h0000};
				4'h9: twiddle_lut = {16'hC4DF, 16'h187E};
				default: twiddle_lut = {16'h4000, 16'h0000};
			endcase
		end
	endfunction

	// Rounds, drops the low bits and clamps to the data width
	function [`FFT_DW-1:0] block_float_unit;
		input signed [33:0] v;
		input        [4:0]  sh;
		reg   signed [33:0] t;
		begin
			t = (v + (34'sh1 <<< (sh - 5'h01))) >>> sh;
			if (t > 34'sh0007FFF)
				block_float_unit = 16'h7FFF;
			else if (t < -34'sh0008000)
				block_float_unit = 16'h8000;
			else
				block_float_unit = t[15:0];
		end
	endfunction

	// Accept on valid and ready in the same cycle
	assign adv = sink_valid & sink_ready_ff;
	// Index restarts with the start marker; source keeps natural order
	assign cur_idx = sink_sop ? 4'h0 : idx_ff;
	assign cur_inv = sink_sop ? inverse : inv_ff;
	// Inverse by swapping real and imaginary at both ends; no 1/N applied
	assign in_re = cur_inv ? sink_imag : sink_real;
	assign in_im = cur_inv ? sink_real : sink_imag;

	// End marker is not needed: the index wraps by itself after N samples
	always @(posedge mclk) begin
		if (!reset_n) begin
			idx_ff <= 4'h0;
			inv_ff <= 1'b0;
		end else if (adv) begin
			idx_ff <= cur_idx + 4'h1;
			inv_ff <= cur_inv;
		end
	end

	// Four stages, delays 8, 4, 2, 1; the second of each pair rotates
	sdf_stage #(.DLOG(`S0_DLOG), .JROT(0)) u_stage0 (
		.mclk    (mclk),
		.reset_n (reset_n),
		.adv     (adv),
		.in_re   (in_re),
		.in_im   (in_im),
		.in_idx  (cur_idx),
		.in_tag  ({1'b1, cur_inv}),
		.out_re  (s0_re),
		.out_im  (s0_im),
		.out_idx (s0_idx),
		.out_tag (s0_tag)
	);
	sdf_stage #(.DLOG(`S1_DLOG), .JROT(1)) u_stage1 (
		.mclk    (mclk),
		.reset_n (reset_n),
		.adv     (adv),
		.in_re   (s0_re),
		.in_im   (s0_im),
		.in_idx  (s0_idx),
		.in_tag  (s0_tag),
		.out_re  (s1_re),
		.out_im  (s1_im),
		.out_idx (s1_idx),
		.out_tag (s1_tag)
	);

	// Twiddle exponent: bit-reversed group number times position in group
	always @* begin
		tw_exp = {2'b00, s1_idx[2], s1_idx[3]} * {2'b00, s1_idx[1:0]};
		tw = twiddle_lut(tw_exp);
		p_rr = $signed(s1_re) * $signed(tw[31:16]);
		p_ii = $signed(s1_im) * $signed(tw[15:0]);
		p_ri = $signed(s1_re) * $signed(tw[15:0]);
		p_ir = $signed(s1_im) * $signed(tw[31:16]);
		mul_re = block_float_unit({{2{p_rr[31]}}, p_rr} - {{2{p_ii[31]}}, p_ii}, `TW_SHIFT);
		mul_im = block_float_unit({{2{p_ri[31]}}, p_ri} + {{2{p_ir[31]}}, p_ir}, `TW_SHIFT);
	end

	// One multiplier stage between the stage pairs
	always @(posedge mclk) begin
		if (!reset_n) begin
			tw_re_ff <= 16'h0000;
			tw_im_ff <= 16'h0000;
			tw_idx_ff <= 4'h0;
			tw_tag_ff <= 2'h0;
		end else if (adv) begin
			tw_re_ff <= mul_re;
			tw_im_ff <= mul_im;
			tw_idx_ff <= s1_idx;
			tw_tag_ff <= s1_tag;
		end
	end

	sdf_stage #(.DLOG(`S2_DLOG), .JROT(0)) u_stage2 (
		.mclk    (mclk),
		.reset_n (reset_n),
		.adv     (adv),
		.in_re   (tw_re_ff),
		.in_im   (tw_im_ff),
		.in_idx  (tw_idx_ff),
		.in_tag  (tw_tag_ff),
		.out_re  (s2_re),
		.out_im  (s2_im),
		.out_idx (s2_idx),
		.out_tag (s2_tag)
	);
	sdf_stage #(.DLOG(`S3_DLOG), .JROT(1)) u_stage3 (
		.mclk    (mclk),
		.reset_n (reset_n),
		.adv     (adv),
		.in_re   (s2_re),
		.in_im   (s2_im),
		.in_idx  (s2_idx),
		.in_tag  (s2_tag),
		.out_re  (s3_re),
		.out_im  (s3_im),
		.out_idx (s3_idx),
		.out_tag (s3_tag)
	);

	// Pipeline output position p holds bin bitrev(p); write it there
	assign wr_en = adv & s3_tag[1];
	assign wr_addr = {wb_ff, bitrev4(s3_idx)};
	assign rd_load = full_ff[rb_ff] & (~src_valid_ff | source_ready);
	assign rd_last = is_last(ridx_ff);
	assign rd_addr = {rb_ff, ridx_ff};

	always @(posedge mclk) begin
		if (wr_en) begin
			bank_re[wr_addr] <= s3_re;
			bank_im[wr_addr] <= s3_im;
		end
	end

	// Bank occupancy; ready looks one cycle ahead so no write lands in a full bank
	always @* begin
		nxt_full = full_ff;
		nxt_wb = wb_ff;
		if (rd_load && rd_last)
			nxt_full[rb_ff] = 1'b0;
		if (wr_en && is_last(s3_idx)) begin
			nxt_full[wb_ff] = 1'b1;
			nxt_wb = ~wb_ff;
		end
	end

	always @(posedge mclk) begin
		if (!reset_n) begin
			full_ff <= 2'b00;
			wb_ff <= 1'b0;
			bank_inv_ff <= 2'b00;
			sink_ready_ff <= 1'b0;
		end else begin
			full_ff <= nxt_full;
			wb_ff <= nxt_wb;
			if (wr_en)
				bank_inv_ff[wb_ff] <= s3_tag[0];
			// Two banks let the source drain one while the other fills
			sink_ready_ff <= ~nxt_full[nxt_wb];
		end
	end

	// Output register: loads only when empty or being taken
	always @(posedge mclk) begin
		if (!reset_n) begin
			rb_ff <= 1'b0;
			ridx_ff <= 4'h0;
			src_valid_ff <= 1'b0;
			src_sop_ff <= 1'b0;
			src_eop_ff <= 1'b0;
			src_re_ff <= 16'h0000;
			src_im_ff <= 16'h0000;
			exp_ff <= 6'h00;
		end else if (rd_load) begin
			src_valid_ff <= 1'b1;
			src_sop_ff <= (ridx_ff == 4'h0);
			src_eop_ff <= rd_last;
			src_re_ff <= bank_inv_ff[rb_ff] ? bank_im[rd_addr] : bank_re[rd_addr];
			src_im_ff <= bank_inv_ff[rb_ff] ? bank_re[rd_addr] : bank_im[rd_addr];
			// Four stages each drop one bit, so the block exponent is fixed
			exp_ff <= `FFT_EXP;
			ridx_ff <= ridx_ff + 4'h1;
			if (rd_last)
				rb_ff <= ~rb_ff;
		end else if (source_ready) begin
			src_valid_ff <= 1'b0;
		end
	end

	assign sink_ready = sink_ready_ff;
	assign source_valid = src_valid_ff;
	assign source_sop = src_sop_ff;
	assign source_eop = src_eop_ff;
	assign source_real = src_re_ff;
	assign source_imag = src_im_ff;
	assign exponent_out = exp_ff;
endmodule
`default_nettype wire

// [rtl/fft_consts.vh]
`ifndef FFT_CONSTS_VH
`define FFT_CONSTS_VH

`define FFT_DW        16
`define FFT_IW        4
`define FFT_LAST_IDX  4'hF
`define FFT_EXP       6'h3C
`define TW_SHIFT      5'h0E
`define S0_DLOG       3
`define S1_DLOG       2
`define S2_DLOG       1
`define S3_DLOG       0

`endif

// [rtl/sdf_stage.v]
`include "fft_consts.vh"
`default_nettype none
module sdf_stage #(
	parameter DLOG = 3,
	parameter JROT = 0
) (
	input  wire                      mclk,
	input  wire                      reset_n,
	input  wire                      adv,
	input  wire [`FFT_DW-1:0]        in_re,
	input  wire [`FFT_DW-1:0]        in_im,
	input  wire [`FFT_IW-1:0]        in_idx,
	input  wire [1:0]                in_tag,
	output wire [`FFT_DW-1:0]        out_re,
	output wire [`FFT_DW-1:0]        out_im,
	output wire [`FFT_IW-1:0]        out_idx,
	output wire [1:0]                out_tag
);
	localparam DLEN = 1 << DLOG;
	localparam [`FFT_IW-1:0] DOFF = 4'h1 << DLOG;

	reg  [33:0]          dly_ff [0:DLEN-1];
	reg  [`FFT_DW-1:0]   out_re_ff;
	reg  [`FFT_DW-1:0]   out_im_ff;
	reg  [`FFT_IW-1:0]   out_idx_ff;
	reg  [1:0]           out_tag_ff;
	reg  [33:0]          fb;
	reg  [`FFT_DW-1:0]   nxt_re;
	reg  [`FFT_DW-1:0]   nxt_im;
	reg  [1:0]           nxt_tag;
	reg  signed [16:0]   x_re;
	reg  signed [16:0]   x_im;
	reg  signed [16:0]   d_re;
	reg  signed [16:0]   d_im;
	wire [`FFT_IW-1:0]   hi = in_idx >> DLOG;
	wire                 sel = hi[0];
	wire                 rot = (JROT != 0) && (hi[1:0] == 2'b11);
	wire [33:0]          dly = dly_ff[DLEN-1];
	integer              i;

	// Halve with rounding; saturate since a difference can reach +65535
	function [`FFT_DW-1:0] half_sat;
		input signed [16:0] v;
		reg   signed [17:0] t;
		begin
			// Concatenation is unsigned; cast so the shift keeps the sign
			t = ($signed({v[16], v}) + 18'sh1) >>> 1;
			if (t > 18'sh07FFF)
				half_sat = 16'h7FFF;
			else if (t < -18'sh08000)
				half_sat = 16'h8000;
			else
				half_sat = t[15:0];
		end
	endfunction

	// Trivial rotation, butterfly and feedback select
	always @* begin
		x_re = {in_re[15], in_re};
		x_im = {in_im[15], in_im};
		if (rot) begin
			x_re = {in_im[15], in_im};
			x_im = -{in_re[15], in_re};
		end
		d_re = {dly[31], dly[31:16]};
		d_im = {dly[15], dly[15:0]};
		if (sel) begin
			fb = {in_tag, half_sat(d_re - x_re), half_sat(d_im - x_im)};
			nxt_re = half_sat(d_re + x_re);
			nxt_im = half_sat(d_im + x_im);
			nxt_tag = in_tag;
		end else begin
			fb = {in_tag, x_re[15:0], x_im[15:0]};
			nxt_re = dly[31:16];
			nxt_im = dly[15:0];
			nxt_tag = dly[33:32];
		end
	end

	// Feedback delay shifts only when a sample is accepted, so stalls keep alignment
	always @(posedge mclk) begin
		if (!reset_n) begin
			for (i = 0; i < DLEN; i = i + 1)
				dly_ff[i] <= 34'h0;
			out_re_ff <= 16'h0000;
			out_im_ff <= 16'h0000;
			out_idx_ff <= 4'h0;
			out_tag_ff <= 2'h0;
		end else if (adv) begin
			dly_ff[0] <= fb;
			for (i = 1; i < DLEN; i = i + 1)
				dly_ff[i] <= dly_ff[i-1];
			out_re_ff <= nxt_re;
			out_im_ff <= nxt_im;
			out_idx_ff <= in_idx - DOFF;
			out_tag_ff <= nxt_tag;
		end
	end

	assign out_re = out_re_ff;
	assign out_im = out_im_ff;
	assign out_idx = out_idx_ff;
	assign out_tag = out_tag_ff;
endmodule
`default_nettype wire

// [testbench/fft_chk.sv]
`include "fft_consts.vh"
`default_nettype none
module fft_chk (
	input wire logic               mclk,
	input wire logic               reset_n,
	input wire logic               sink_ready,
	input wire logic               source_ready,
	input wire logic               source_valid,
	input wire logic               source_sop,
	input wire logic               source_eop,
	input wire logic [`FFT_DW-1:0] source_real,
	input wire logic [`FFT_DW-1:0] source_imag,
	input wire logic [5:0]         exponent_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] cnt_ff;
	logic [4:0] nxt_cnt;
	// Bins taken since the last start marker
	always @* begin
		nxt_cnt = cnt_ff;
		if (source_valid && source_ready)
			nxt_cnt = source_sop ? 5'h01 : cnt_ff + 5'h01;
	end
	always @(posedge mclk) begin
		cnt_ff <= !reset_n ? 5'h00 : nxt_cnt;
	end
	default clocking cb @(posedge mclk); endclocking
	property p_hold_valid;
		disable iff (!reset_n) source_valid && !source_ready |=> source_valid;
	endproperty
	a_hold_valid: assert property (p_hold_valid)
		else $error("valid dropped while stalled");
	property p_hold_data;
		disable iff (!reset_n) source_valid && !source_ready |=>
			$stable(source_real) && $stable(source_imag) && $stable(exponent_out);
	endproperty
	a_hold_data: assert property (p_hold_data)
		else $error("data moved while stalled");
	property p_hold_marks;
		disable iff (!reset_n) source_valid && !source_ready |=>
			$stable(source_sop) && $stable(source_eop);
	endproperty
	a_hold_marks: assert property (p_hold_marks)
		else $error("marker moved while stalled");
	property p_sop_start;
		disable iff (!reset_n) source_valid && source_sop |-> cnt_ff == 5'h00 || cnt_ff == 5'h10;
	endproperty
	a_sop_start: assert property (p_sop_start)
		else $error("start marker inside a block");
	property p_eop_count;
		disable iff (!reset_n) source_valid && source_eop |-> cnt_ff == 5'h0F;
	endproperty
	a_eop_count: assert property (p_eop_count)
		else $error("end marker not on the 16th bin");
	property p_eop_next;
		disable iff (!reset_n) source_valid && source_ready && source_eop |=>
			!source_valid || source_sop;
	endproperty
	a_eop_next: assert property (p_eop_next)
		else $error("block after end lacks start marker");
	property p_exp;
		disable iff (!reset_n) source_valid |-> exponent_out == `FFT_EXP;
	endproperty
	a_exp: assert property (p_exp)
		else $error("wrong block exponent");
	property p_reset;
		!reset_n |=> !source_valid && !sink_ready && exponent_out == 6'h00;
	endproperty
	a_reset: assert property (p_reset)
		else $error("outputs not cleared by reset");
	property p_ready_rel;
		!reset_n ##1 reset_n |=> sink_ready;
	endproperty
	a_ready_rel: assert property (p_ready_rel)
		else $error("not ready after reset");
endmodule
`default_nettype wire

// [testbench/stream_partner.sv]
`include "fft_consts.vh"
`default_nettype none
module stream_partner (
	input wire logic               mclk,
	input wire logic               sink_ready,
	output var logic               sink_valid,
	output var logic               sink_sop,
	output var logic               sink_eop,
	output var logic               inverse,
	output var logic [`FFT_DW-1:0] sink_real,
	output var logic [`FFT_DW-1:0] sink_imag,
	output var logic               source_ready,
	input wire logic               source_valid,
	input wire logic               source_sop,
	input wire logic               source_eop,
	input wire logic [`FFT_DW-1:0] source_real,
	input wire logic [`FFT_DW-1:0] source_imag
);
	timeunit 1ns;
	timeprecision 1ns;
	logic        stall = 1'b0;
	logic [1:0]  phase = 2'h0;
	logic        rdy;
	int          n_wait = 0;
	logic [33:0] q[$];
	initial begin
		{sink_valid, sink_sop, sink_eop, inverse} = 4'h0;
		{sink_real, sink_imag, source_ready} = 33'h0;
	end
	// Sink: ready is tied high or low one cycle in three; values stable till next edge
	always @(negedge mclk) begin
		rdy = !stall || phase != 2'h0;
		source_ready = rdy;
		phase = (phase == 2'h2) ? 2'h0 : phase + 2'h1;
	end
	// Take a bin at the rising edge where valid and ready meet
	always @(posedge mclk) begin
		if (source_valid && source_ready)
			q.push_back({source_sop, source_eop, source_real, source_imag});
	end
	// Source: drop valid and markers once a run has no more samples
	task automatic idle;
		@(negedge mclk);
		sink_valid = 1'b0;
		sink_sop = 1'b0;
		sink_eop = 1'b0;
	endtask
	// Source: hold the sample until taken, then scramble released lines
	task automatic put(input logic [15:0] re, input logic sop, eop, inv, input int gap);
		@(negedge mclk);
		sink_valid = 1'b1;
		sink_sop = sop;
		sink_eop = eop;
		inverse = inv;
		sink_real = re;
		sink_imag = 16'h0000;
		while (sink_ready !== 1'b1) begin
			@(negedge mclk);
			n_wait++;
		end
		@(posedge mclk);
		repeat (gap) begin
			@(negedge mclk);
			sink_valid = 1'b0;
			sink_real = ~re;
			sink_imag = 16'hFFFF;
		end
	endtask
endmodule
`default_nettype wire

// [testbench/streaming_fft_core_tb.sv]
`include "fft_consts.vh"
`default_nettype none
module streaming_fft_core_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic sink_valid, sink_ready, sink_sop, sink_eop, inverse, source_ready;
	logic source_valid, source_sop, source_eop;
	logic [`FFT_DW-1:0] sink_real, sink_imag, source_real, source_imag;
	logic [5:0] exponent_out;
	int n_fail = 0;
	int total_checks = 0;
	int cyc = 0;
	streaming_fft_core dut (.mclk(mclk), .reset_n(reset_n), .sink_valid(sink_valid),
		.sink_ready(sink_ready), .sink_sop(sink_sop), .sink_eop(sink_eop),
		.inverse(inverse), .sink_real(sink_real), .sink_imag(sink_imag),
		.source_ready(source_ready), .source_valid(source_valid), .source_sop(source_sop),
		.source_eop(source_eop), .source_real(source_real), .source_imag(source_imag),
		.exponent_out(exponent_out));
	stream_partner part (.mclk(mclk), .sink_ready(sink_ready), .sink_valid(sink_valid),
		.sink_sop(sink_sop), .sink_eop(sink_eop), .inverse(inverse),
		.sink_real(sink_real), .sink_imag(sink_imag), .source_ready(source_ready),
		.source_valid(source_valid), .source_sop(source_sop), .source_eop(source_eop),
		.source_real(source_real), .source_imag(source_imag));
	always #25 mclk = ~mclk;
	// Hang guard: the two runs need far fewer cycles
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			report_and_stop();
		end
	end
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Input of block b: impulse, DC, then an impulse at index 4 in blocks 2 and 3, then zeros
	function automatic logic [15:0] smp(input int b, i);
		if (b == 0)
			return (i == 0) ? 16'h1000 : 16'h0000;
		if (b == 1)
			return 16'h0100;
		if (b < 4)
			return (i == 4) ? 16'h1000 : 16'h0000;
		return 16'h0000;
	endfunction
	// Bins scaled by 1/16 from the fixed exponent; block 2 is inverse
	function automatic logic [31:0] exp_bin(input int b, k);
		if (b == 0)
			return 32'h01000000;
		if (b == 1)
			return (k == 0) ? 32'h01000000 : 32'h0;
		case (k % 4)
			0: return 32'h01000000;
			1: return (b == 2) ? 32'h00000100 : 32'h0000FF00;
			2: return 32'hFF000000;
			default: return (b == 2) ? 32'h0000FF00 : 32'h00000100;
		endcase
	endfunction
	// Ten cycles of reset, mid-stream on the second call
	task automatic do_reset;
		@(negedge mclk);
		reset_n = 1'b0;
		repeat (10) @(negedge mclk);
		check("reset", {sink_ready, source_valid, exponent_out}, 32'h0);
		part.q.delete();
		part.n_wait = 0;
		reset_n = 1'b1;
		@(negedge mclk);
		check("ready", sink_ready, 32'h1);
	endtask
	task automatic run_blocks(input string name, input logic stl, input int gap);
		int n;
		logic [33:0] e;
		do_reset();
		part.stall = stl;
		for (int b = 0; b < 6; b++) begin
			for (int i = 0; i < 16; i++)
				part.put(smp(b, i), i == 0, i == 15, b == 2, gap);
		end
		// A held valid would feed a stale sample into the next run
		part.idle();
		n = 0;
		while (part.q.size() < 64 && n < 500) begin
			@(negedge mclk);
			n++;
		end
		check("bins", part.q.size() >= 64, 32'h1);
		if (!stl)
			check("stalls", part.n_wait, 32'h0);
		for (int j = 0; j < 64 && j < part.q.size(); j++) begin
			e = part.q[j];
			check("sop", e[33], j % 16 == 0);
			check("eop", e[32], j % 16 == 15);
			check("bin", e[31:0], exp_bin(j / 16, j % 16));
		end
		$display("test %s done", name);
	endtask
	initial begin
		run_blocks("back_to_back", 1'b0, 0);
		run_blocks("stall_and_gaps", 1'b1, 2);
		report_and_stop();
	end
endmodule
bind streaming_fft_core fft_chk u_chk (.mclk(mclk), .reset_n(reset_n),
	.sink_ready(sink_ready), .source_ready(source_ready), .source_valid(source_valid),
	.source_sop(source_sop), .source_eop(source_eop), .source_real(source_real),
	.source_imag(source_imag), .exponent_out(exponent_out));
`default_nettype wire
